// File: core/tmr2_map.svh
// Register offsets, field positions, reset values and counts for the timer block.
// Function
// - Clock select 0 stops, 1 undivided, 2..7 divide by 8,32,64,128,256,1024.
// - Non-PWM pin action: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM: 2 clear on match set at TOP, 3 inverse, 1 reserved.
// - Phase-correct: 2 clear on up-match set on down-match, 3 inverse.
// - Waveform mode field selects mode and TOP; 4 and 6 reserved.
// - Compare update immediately or at TOP; overflow flag at MAX, BOTTOM or TOP.
// - Software reads and writes the 8-bit count directly.
// - A count write suppresses compare match during the next timer clock.
// - Software count write beats hardware clear, increment or decrement.
// - With no clock selected the count holds; software access still works.
// - Compare A matched continuously, raises interrupt A and drives pin A.
// - Compare B matched continuously, raises interrupt B and drives pin B.
// - PWM modes double-buffer compare values, reloaded at TOP; others bypass.
// - Software compare access reaches buffer when buffered, active value otherwise.
// - Match sets channel flag; enable and global enable raise interrupt.
// - Match flags clear on service acknowledge or by writing one.
// - A config bit selects system clock or external clock as prescaler input.
`ifndef TMR2_MAP_SVH
`define TMR2_MAP_SVH
`define TMR2_ADDR_FLAGS 8'h37
`define TMR2_ADDR_ENABLES 8'h70
`define TMR2_ADDR_CTRL_A 8'hB0
`define TMR2_ADDR_CTRL_B 8'hB1
`define TMR2_ADDR_COUNT 8'hB2
`define TMR2_ADDR_CMP_A 8'hB3
`define TMR2_ADDR_CMP_B 8'hB4
`define TMR2_ADDR_ASYNC 8'hB6
`define TMR2_BIT_OVF 0
`define TMR2_BIT_CMPA 1
`define TMR2_BIT_CMPB 2
`define TMR2_BIT_ASYNC 5
`define TMR2_ACT_A_MSB 7
`define TMR2_ACT_A_LSB 6
`define TMR2_ACT_B_MSB 5
`define TMR2_ACT_B_LSB 4
`define TMR2_MODE_LO_MSB 1
`define TMR2_MODE_LO_LSB 0
`define TMR2_MODE_HI_BIT 3
`define TMR2_CS_MSB 2
`define TMR2_CS_LSB 0
`define TMR2_RESET_BYTE 8'h00
`define TMR2_MAX 8'hFF
`define TMR2_BOTTOM 8'h00
`define TMR2_ONE 8'h01
`define TMR2_PS_ONE 10'h001
`define TMR2_PS_DIV8 10'h007
`define TMR2_PS_DIV32 10'h01F
`define TMR2_PS_DIV64 10'h03F
`define TMR2_PS_DIV128 10'h07F
`define TMR2_PS_DIV256 10'h0FF
`define TMR2_PS_DIV1024 10'h3FF
`endif

// File: core/tmr2_pkg.sv
// Types shared by the timer block.
package tmr2_pkg;
	typedef enum logic [6:0] {
		TMR2_NORMAL = 7'h01,
		TMR2_PC_FF = 7'h02,
		TMR2_CTC = 7'h04,
		TMR2_FP_FF = 7'h08,
		TMR2_PC_A = 7'h10,
		TMR2_FP_A = 7'h20,
		TMR2_RSVD = 7'h40
	} tmr2_mode_e;
endpackage

// File: core/tmr2_timer.sv
// Eight-bit timer with two compare channels, PWM modes and interrupt flags.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "tmr2_map.svh"
module tmr2_timer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic ext_clk_tick,
	input wire logic global_irq_enable,
	input wire logic irq_ack_ovf,
	input wire logic irq_ack_cmpa,
	input wire logic irq_ack_cmpb,
	output logic waveform_pin_a,
	output logic waveform_pin_a_en,
	output logic waveform_pin_b,
	output logic waveform_pin_b_en,
	output logic irq
);
	// ==========================================================
	// Registers and decode
	logic [1:0] compare_pin_action_a_q;
	logic [1:0] compare_pin_action_b_q;
	logic [2:0] waveform_mode_select_q;
	logic [2:0] clock_source_select_q;
	logic async_clock_select_q;
	logic [7:0] count_value_q;
	logic [7:0] compare_a_value_q;
	logic [7:0] compare_b_value_q;
	logic [7:0] compare_a_buf_q;
	logic [7:0] compare_b_buf_q;
	logic [2:0] irq_enable_q;
	logic [2:0] irq_flag_q;
	logic [9:0] presc_q;
	logic dir_down_q;
	logic suppress_q;
	logic ext_prev_q;
	logic wr_ctrl_a;
	logic wr_ctrl_b;
	logic wr_count;
	logic wr_cmp_a;
	logic wr_cmp_b;
	logic wr_flags;
	logic wr_en;
	logic wr_async;
	// Every write strobe is decoded to one enable per register here.
	// Writes to addresses outside the map match none of these and are dropped.
	// Reads are handled separately at the bottom of the file, so a write and
	// a read never share decode logic and the bus master may alternate freely.
	// All decodes are combinational; the registers they feed take the data on
	// the same edge that samples the strobe.
	assign wr_ctrl_a = reg_write && (reg_addr == `TMR2_ADDR_CTRL_A);
	assign wr_ctrl_b = reg_write && (reg_addr == `TMR2_ADDR_CTRL_B);
	assign wr_count = reg_write && (reg_addr == `TMR2_ADDR_COUNT);
	assign wr_cmp_a = reg_write && (reg_addr == `TMR2_ADDR_CMP_A);
	assign wr_cmp_b = reg_write && (reg_addr == `TMR2_ADDR_CMP_B);
	assign wr_flags = reg_write && (reg_addr == `TMR2_ADDR_FLAGS);
	assign wr_en = reg_write && (reg_addr == `TMR2_ADDR_ENABLES);
	assign wr_async = reg_write && (reg_addr == `TMR2_ADDR_ASYNC);

	// ==========================================================
	// Mode decode
	tmr2_pkg::tmr2_mode_e mode;
	logic is_pwm;
	logic is_fast;
	logic [7:0] top;
	// The three mode bits live in two control registers, so a mode change
	// written as two bytes passes briefly through an intermediate mode.
	// Software should stop the clock before changing mode to avoid a stray
	// period. Reserved codes decode to a state that counts like normal mode
	// but never raises the overflow flag.
	always_comb begin
		case (waveform_mode_select_q)
			3'h0: mode = tmr2_pkg::TMR2_NORMAL;
			3'h1: mode = tmr2_pkg::TMR2_PC_FF;
			3'h2: mode = tmr2_pkg::TMR2_CTC;
			3'h3: mode = tmr2_pkg::TMR2_FP_FF;
			3'h5: mode = tmr2_pkg::TMR2_PC_A;
			3'h7: mode = tmr2_pkg::TMR2_FP_A;
			default: mode = tmr2_pkg::TMR2_RSVD;
		endcase
	end
	assign is_fast = (mode == tmr2_pkg::TMR2_FP_FF) || (mode == tmr2_pkg::TMR2_FP_A);
	assign is_pwm = is_fast || (mode == tmr2_pkg::TMR2_PC_FF) || (mode == tmr2_pkg::TMR2_PC_A);
	// Register A sets TOP in CTC and the A-topped PWM modes.
	assign top = ((mode == tmr2_pkg::TMR2_CTC) || (mode == tmr2_pkg::TMR2_PC_A) ||
		(mode == tmr2_pkg::TMR2_FP_A)) ? compare_a_value_q : `TMR2_MAX;

	// ==========================================================
	// Prescaler and timer tick
	logic src_tick;
	logic [9:0] div_mask;
	logic tick;
	// The prescaler is shared by all divide ratios and is never cleared by a
	// clock-select change, so the first tick after selecting a ratio may come
	// early. This trades a predictable first period for less logic.
	// A divided tick fires when the low prescaler bits are all ones; the mask
	// for the chosen ratio picks how many bits take part.
	// With the external source selected, both the prescaler and the undivided
	// tick advance only on a rising level of the external strobe.
	// The external source is a synchronous strobe here; one edge per rising level.
	assign src_tick = async_clock_select_q ? (ext_clk_tick && !ext_prev_q) : 1'b1;
	always_comb begin
		case (clock_source_select_q)
			3'h2: div_mask = `TMR2_PS_DIV8;
			3'h3: div_mask = `TMR2_PS_DIV32;
			3'h4: div_mask = `TMR2_PS_DIV64;
			3'h5: div_mask = `TMR2_PS_DIV128;
			3'h6: div_mask = `TMR2_PS_DIV256;
			3'h7: div_mask = `TMR2_PS_DIV1024;
			default: div_mask = 10'h000;
		endcase
	end
	assign tick = src_tick && (clock_source_select_q != 3'h0) &&
		((clock_source_select_q == 3'h1) || ((presc_q & div_mask) == div_mask));

	// Free-running prescaler advances on every source edge.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			presc_q <= 10'h000;
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_clk_tick;
			if (src_tick) begin
				presc_q <= presc_q + `TMR2_PS_ONE;
			end
		end
	end

	// ==========================================================
	// Control registers
	// Mode, pin actions, clock select and the enable mask are plain storage.
	// Reserved bits are dropped on write and read back as zero.
	// The source select takes effect on the edge after its write.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			compare_pin_action_a_q <= 2'h0;
			compare_pin_action_b_q <= 2'h0;
			waveform_mode_select_q <= 3'h0;
			clock_source_select_q <= 3'h0;
			async_clock_select_q <= 1'b0;
			irq_enable_q <= 3'h0;
		end else begin
			if (wr_ctrl_a) begin
				compare_pin_action_a_q <= reg_wdata[`TMR2_ACT_A_MSB:`TMR2_ACT_A_LSB];
				compare_pin_action_b_q <= reg_wdata[`TMR2_ACT_B_MSB:`TMR2_ACT_B_LSB];
				waveform_mode_select_q[1:0] <= reg_wdata[`TMR2_MODE_LO_MSB:`TMR2_MODE_LO_LSB];
			end
			if (wr_ctrl_b) begin
				waveform_mode_select_q[2] <= reg_wdata[`TMR2_MODE_HI_BIT];
				clock_source_select_q <= reg_wdata[`TMR2_CS_MSB:`TMR2_CS_LSB];
			end
			if (wr_async) begin
				async_clock_select_q <= reg_wdata[`TMR2_BIT_ASYNC];
			end
			if (wr_en) begin
				irq_enable_q <= reg_wdata[`TMR2_BIT_CMPB:`TMR2_BIT_OVF];
			end
		end
	end

	// ==========================================================
	// Counter
	logic at_top;
	logic at_bottom;
	logic match_a;
	logic match_b;
	// The counter turns at TOP in the single-slope modes and changes
	// direction at TOP and BOTTOM in phase-correct mode. A software write
	// always wins over the hardware step in the same cycle. Matches only
	// count on tick cycles, so a prescaled timer raises each event once per
	// timer clock rather than once per system clock. Writing the count equal
	// to a compare value loses that match, as the suppression window covers it.
	assign at_top = (count_value_q == top);
	assign at_bottom = (count_value_q == `TMR2_BOTTOM);
	// Matches are continuous compares, gated after a software count write.
	assign match_a = tick && !suppress_q && (count_value_q == compare_a_value_q);
	assign match_b = tick && !suppress_q && (count_value_q == compare_b_value_q);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_value_q <= `TMR2_RESET_BYTE;
			dir_down_q <= 1'b0;
			suppress_q <= 1'b0;
		end else begin
			// Suppression lasts until the next timer tick, even when stopped.
			if (wr_count) begin
				suppress_q <= 1'b1;
			end else if (tick) begin
				suppress_q <= 1'b0;
			end
			if (wr_count) begin
				count_value_q <= reg_wdata;
			end else if (tick) begin
				if (is_pwm && !is_fast) begin
					if (!dir_down_q) begin
						if (at_top) begin
							dir_down_q <= 1'b1;
							count_value_q <= count_value_q - `TMR2_ONE;
						end else begin
							count_value_q <= count_value_q + `TMR2_ONE;
						end
					end else if (at_bottom) begin
						dir_down_q <= 1'b0;
						count_value_q <= count_value_q + `TMR2_ONE;
					end else begin
						count_value_q <= count_value_q - `TMR2_ONE;
					end
				end else if (at_top) begin
					count_value_q <= `TMR2_BOTTOM;
					dir_down_q <= 1'b0;
				end else begin
					count_value_q <= count_value_q + `TMR2_ONE;
					dir_down_q <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Compare registers with double buffering
	// Reload only at TOP so a PWM period never sees a half-updated duty.
	// Writes always land in the buffer, so a read in a PWM mode returns the
	// value that will take effect, not the one in use. Outside PWM modes the
	// active value follows the write on the same edge.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			compare_a_value_q <= `TMR2_RESET_BYTE;
			compare_b_value_q <= `TMR2_RESET_BYTE;
			compare_a_buf_q <= `TMR2_RESET_BYTE;
			compare_b_buf_q <= `TMR2_RESET_BYTE;
		end else begin
			if (wr_cmp_a) begin
				compare_a_buf_q <= reg_wdata;
			end
			if (wr_cmp_b) begin
				compare_b_buf_q <= reg_wdata;
			end
			if (!is_pwm) begin
				if (wr_cmp_a) begin
					compare_a_value_q <= reg_wdata;
				end
				if (wr_cmp_b) begin
					compare_b_value_q <= reg_wdata;
				end
			end else if (tick && at_top) begin
				compare_a_value_q <= compare_a_buf_q;
				compare_b_value_q <= compare_b_buf_q;
			end
		end
	end

	// ==========================================================
	// Interrupt flags
	logic ovf_evt;
	logic [2:0] set_v;
	logic [2:0] clr_v;
	// Flags are sticky: hardware events set them, and either a one written
	// to the flag register or a service acknowledge clears them.
	// The interrupt output is registered, so it follows the flags one edge
	// later and drops one edge after the last enabled flag clears.
	always_comb begin
		// Overflow at MAX for 0,2,3, at BOTTOM for phase-correct, at TOP for 7.
		case (mode)
			tmr2_pkg::TMR2_NORMAL: ovf_evt = tick && (count_value_q == `TMR2_MAX);
			tmr2_pkg::TMR2_CTC: ovf_evt = tick && (count_value_q == `TMR2_MAX);
			tmr2_pkg::TMR2_FP_FF: ovf_evt = tick && (count_value_q == `TMR2_MAX);
			tmr2_pkg::TMR2_PC_FF: ovf_evt = tick && at_bottom && dir_down_q;
			tmr2_pkg::TMR2_PC_A: ovf_evt = tick && at_bottom && dir_down_q;
			tmr2_pkg::TMR2_FP_A: ovf_evt = tick && at_top;
			default: ovf_evt = 1'b0;
		endcase
	end
	assign set_v = {match_b, match_a, ovf_evt};
	assign clr_v = ({3{wr_flags}} & reg_wdata[`TMR2_BIT_CMPB:`TMR2_BIT_OVF]) |
		{irq_ack_cmpb, irq_ack_cmpa, irq_ack_ovf};
	// A new event in the clearing cycle wins over the clear.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_flag_q <= 3'h0;
		end else begin
			irq_flag_q <= (irq_flag_q & ~clr_v) | set_v;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= global_irq_enable && |(irq_flag_q & irq_enable_q);
		end
	end

	// ==========================================================
	// Waveform outputs
	logic pin_a_d;
	logic pin_b_d;
	// One helper computes the next pin level for either channel, from the
	// current level, its pin action and the counter state.
	// The pin keeps its level while disconnected, so reconnecting it resumes
	// from the last driven value rather than from a reset level.
	function automatic logic wave_next(input logic cur, input logic [1:0] act,
		input logic hit, input logic fast, input logic pwm, input logic dn,
		input logic attop, input logic tk);
		logic r;
		r = cur;
		if (!pwm) begin
			if (hit) begin
				case (act)
					2'h1: r = !cur;
					2'h2: r = 1'b0;
					2'h3: r = 1'b1;
					default: r = cur;
				endcase
			end
		end else if (fast) begin
			if (act[1]) begin
				if (tk && attop) begin
					r = !act[0];
				end else if (hit) begin
					r = act[0];
				end
			end
		end else if (act[1] && hit) begin
			r = act[0] ^ dn;
		end
		return r;
	endfunction
	assign pin_a_d = wave_next(waveform_pin_a, compare_pin_action_a_q, match_a, is_fast,
		is_pwm, dir_down_q, at_top, tick);
	assign pin_b_d = wave_next(waveform_pin_b, compare_pin_action_b_q, match_b, is_fast,
		is_pwm, dir_down_q, at_top, tick);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			waveform_pin_a <= 1'b0;
			waveform_pin_b <= 1'b0;
			waveform_pin_a_en <= 1'b0;
			waveform_pin_b_en <= 1'b0;
		end else begin
			waveform_pin_a <= pin_a_d;
			waveform_pin_b <= pin_b_d;
			// Action 0 hands the pin back to general I/O.
			waveform_pin_a_en <= (compare_pin_action_a_q != 2'h0);
			waveform_pin_b_en <= (compare_pin_action_b_q != 2'h0);
		end
	end

	// ==========================================================
	// Read path, data one cycle after the strobe
	// Read data is zero in every cycle that does not follow a read strobe,
	// so the bus may OR several slaves together.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= `TMR2_RESET_BYTE;
		end else if (reg_read) begin
			case (reg_addr)
				`TMR2_ADDR_CTRL_A: reg_rdata <= {compare_pin_action_a_q, compare_pin_action_b_q,
					2'h0, waveform_mode_select_q[1:0]};
				`TMR2_ADDR_CTRL_B: reg_rdata <= {4'h0, waveform_mode_select_q[2],
					clock_source_select_q};
				`TMR2_ADDR_COUNT: reg_rdata <= count_value_q;
				`TMR2_ADDR_CMP_A: reg_rdata <= is_pwm ? compare_a_buf_q : compare_a_value_q;
				`TMR2_ADDR_CMP_B: reg_rdata <= is_pwm ? compare_b_buf_q : compare_b_value_q;
				`TMR2_ADDR_ASYNC: reg_rdata <= {2'h0, async_clock_select_q, 5'h00};
				`TMR2_ADDR_ENABLES: reg_rdata <= {5'h00, irq_enable_q};
				`TMR2_ADDR_FLAGS: reg_rdata <= {5'h00, irq_flag_q};
				default: reg_rdata <= `TMR2_RESET_BYTE;
			endcase
		end else begin
			reg_rdata <= `TMR2_RESET_BYTE;
		end
	end
endmodule

// File: dv/tmr2_timer_sva.sv
// Checker of register reads, interrupt gating and pin enables at the timer ports.
`timescale 1ns/1ps
module tmr2_timer_sva (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic global_irq_enable,
	input wire logic waveform_pin_a_en,
	input wire logic waveform_pin_b_en,
	input wire logic irq
);
	logic [7:0] en_q, ctl_q, cs_q, cnt_q;
	logic hold_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// Shadows
	// Copies of software writes; hold_q says the count was written with no clock since.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			{en_q, ctl_q, cs_q, cnt_q} <= 32'h00000000;
			hold_q <= 1'b0;
		end else begin
			if (reg_write && reg_addr == 8'h70) en_q <= reg_wdata;
			if (reg_write && reg_addr == 8'hB0) ctl_q <= reg_wdata;
			if (reg_write && reg_addr == 8'hB1) cs_q <= reg_wdata;
			if (reg_write && reg_addr == 8'hB2) cnt_q <= reg_wdata;
			hold_q <= (reg_write && reg_addr == 8'hB2) || (hold_q && cs_q[2:0] == 3'h0);
		end
	end
	// ==========
	// Properties
	property p_rdata_idle;
		!reg_read |=> reg_rdata == 8'h00;
	endproperty
	property p_irq_gated;
		!global_irq_enable |=> !irq;
	endproperty
	property p_irq_masked;
		en_q[2:0] == 3'h0 |=> !irq;
	endproperty
	property p_pin_a_off;
		ctl_q[7:6] == 2'h0 [*3] |-> !waveform_pin_a_en;
	endproperty
	property p_pin_b_on;
		ctl_q[5:4] != 2'h0 [*3] |-> waveform_pin_b_en;
	endproperty
	property p_count_hold;
		reg_read && reg_addr == 8'hB2 && hold_q && cs_q[2:0] == 3'h0 |=> reg_rdata == cnt_q;
	endproperty
	property p_en_read;
		reg_read && reg_addr == 8'h70 |=> reg_rdata == {5'h00, en_q[2:0]};
	endproperty
	property p_unmapped;
		reg_read && !(reg_addr inside {8'h37, 8'h70, [8'hB0:8'hB4], 8'hB6}) |=> reg_rdata == 8'h00;
	endproperty
	// Stopped timer raises no events, so a one-written flag must read back clear.
	property p_flag_clear;
		reg_write && reg_addr == 8'h37 && reg_wdata == 8'h07 && cs_q[2:0] == 3'h0 ##2
			reg_read && reg_addr == 8'h37 && cs_q[2:0] == 3'h0 |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle:
		assert property (p_rdata_idle) else $error("read data not zero when idle");
	a_irq_gated:
		assert property (p_irq_gated) else $error("irq without global enable");
	a_irq_masked:
		assert property (p_irq_masked) else $error("irq with all enables clear");
	a_pin_a_off:
		assert property (p_pin_a_off) else $error("pin a enabled while disconnected");
	a_pin_b_on:
		assert property (p_pin_b_on) else $error("pin b not enabled");
	a_count_hold:
		assert property (p_count_hold) else $error("stopped count changed");
	a_en_read:
		assert property (p_en_read) else $error("enable readback wrong");
	a_unmapped:
		assert property (p_unmapped) else $error("unmapped read not zero");
	a_flag_clear:
		assert property (p_flag_clear) else $error("flag not cleared by one");
	c_irq: cover property ($rose(irq));
	c_hold: cover property (hold_q && reg_read);
	c_flag: cover property (reg_read && reg_addr == 8'h37 ##1 reg_rdata != 8'h00);
endmodule
bind tmr2_timer tmr2_timer_sva tmr2_timer_sva_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.global_irq_enable(global_irq_enable), .waveform_pin_a_en(waveform_pin_a_en),
	.waveform_pin_b_en(waveform_pin_b_en), .irq(irq)
);

// File: dv/tmr2_timer_tb.sv
// Self-checking bench for the eight-bit timer with two compare channels.
`timescale 1ns/1ps
module tmr2_timer_tb;
	logic ref_clk, rst_n, reg_write, reg_read, ext_clk_tick, global_irq_enable, irq;
	logic irq_ack_ovf, irq_ack_cmpa, irq_ack_cmpb;
	logic waveform_pin_a, waveform_pin_a_en, waveform_pin_b, waveform_pin_b_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	int fails = 0;
	int check_count = 0;
	int n;
	logic [15:0] d0, d1;
	int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	logic [7:0] regs[6] = '{8'h37, 8'h70, 8'hB2, 8'hB3, 8'hB4, 8'h01};
	tmr2_timer tmr2_timer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .ext_clk_tick(ext_clk_tick),
		.global_irq_enable(global_irq_enable), .irq_ack_ovf(irq_ack_ovf),
		.irq_ack_cmpa(irq_ack_cmpa), .irq_ack_cmpb(irq_ack_cmpb),
		.waveform_pin_a(waveform_pin_a), .waveform_pin_a_en(waveform_pin_a_en),
		.waveform_pin_b(waveform_pin_b), .waveform_pin_b_en(waveform_pin_b_en), .irq(irq));
	// Free-running 40 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// ==========
	// Bus and compare tasks
	// Each access leaves one idle edge, so no strobe is driven twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		{reg_addr, reg_wdata, reg_write} <= {a, v, 1'b1};
		@(posedge ref_clk);
		reg_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge ref_clk);
		reg_read <= 1'b0;
		@(posedge ref_clk);
		v = {8'h00, reg_rdata};
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		chk("register", e, v & m);
	endtask
	task automatic ack(input int w);
		{irq_ack_ovf, irq_ack_cmpa, irq_ack_cmpb} <= {w == 0, w == 1, w == 2};
		@(posedge ref_clk);
		{irq_ack_ovf, irq_ack_cmpa, irq_ack_cmpb} <= 3'h0;
		@(posedge ref_clk);
	endtask
	task automatic wt_irq();
		for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge ref_clk);
		chk("irq", 16'h0001, {15'h0000, irq});
	endtask
	// Length of the next full stretch at level v, skipping any stretch under way.
	task automatic meas(input bit b, input logic v, output int k);
		k = 0;
		for (int i = 0; i < 2000 && (b ? waveform_pin_b : waveform_pin_a) === v; i++)
			@(posedge ref_clk);
		for (int i = 0; i < 2000 && (b ? waveform_pin_b : waveform_pin_a) !== v; i++)
			@(posedge ref_clk);
		for (int i = 0; i < 2000 && (b ? waveform_pin_b : waveform_pin_a) === v; i++) begin
			k++;
			@(posedge ref_clk);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========
	// Scenarios
	task automatic t_reset();
		wr(8'h01, 8'hFF);
		foreach (regs[i]) rc(regs[i], 16'h00FF, 16'h0000);
	endtask
	task automatic t_clk();
		wr(8'hB2, 8'h5A);
		repeat (5) @(posedge ref_clk);
		rc(8'hB2, 16'h00FF, 16'h005A);
		for (int i = 1; i < 8; i++) begin
			wr(8'hB1, 8'(i));
			rd(8'hB2, d0);
			repeat (2 * dv[i] - 2) @(posedge ref_clk);
			rd(8'hB2, d1);
			chk("ticks", 16'h0002, (d1 - d0) & 16'h00FF);
		end
		wr(8'hB1, 8'h01);
		wr(8'hB2, 8'h77);
		rc(8'hB2, 16'h00FF, 16'h0078);
		wr(8'hB1, 8'h00);
	endtask
	task automatic t_supp();
		wr(8'h37, 8'h07);
		rc(8'h37, 16'h0007, 16'h0000);
		wr(8'hB3, 8'h20);
		wr(8'hB2, 8'h20);
		wr(8'hB1, 8'h01);
		wr(8'hB1, 8'h00);
		rc(8'h37, 16'h0002, 16'h0000);
	endtask
	task automatic t_cmpa();
		global_irq_enable <= 1'b1;
		wr(8'hB3, 8'h10);
		wr(8'hB0, 8'h40);
		wr(8'h70, 8'h02);
		wr(8'hB2, 8'h0E);
		wr(8'hB1, 8'h01);
		wt_irq();
		wr(8'hB1, 8'h00);
		rc(8'h37, 16'h0002, 16'h0002);
		chk("pin a", 16'h0001, {15'h0000, waveform_pin_a});
		ack(1);
		rc(8'h37, 16'h0002, 16'h0000);
	endtask
	task automatic t_ovf();
		wr(8'hB0, 8'h00);
		wr(8'h70, 8'h01);
		wr(8'hB2, 8'hFD);
		wr(8'hB1, 8'h01);
		wt_irq();
		wr(8'hB1, 8'h00);
		rc(8'h37, 16'h0001, 16'h0001);
		ack(0);
		rc(8'h37, 16'h0001, 16'h0000);
	endtask
	task automatic t_async();
		wr(8'hB6, 8'h20);
		wr(8'hB2, 8'h00);
		wr(8'hB1, 8'h01);
		repeat (5) begin
			ext_clk_tick <= 1'b1;
			repeat (3) @(posedge ref_clk);
			ext_clk_tick <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
		wr(8'hB1, 8'h00);
		rc(8'hB2, 16'h00FF, 16'h0005);
		wr(8'hB6, 8'h00);
	endtask
	task automatic t_pwm();
		wr(8'hB4, 8'h80);
		wr(8'hB2, 8'hF0);
		wr(8'hB0, 8'h23);
		wr(8'hB1, 8'h01);
		meas(1'b1, 1'b1, n);
		chk("fast high", 16'h0081, 16'(n));
		wr(8'hB4, 8'h40);
		rc(8'hB4, 16'h00FF, 16'h0040);
		meas(1'b1, 1'b1, n);
		chk("reload high", 16'h0041, 16'(n));
		wr(8'hB1, 8'h00);
		ack(2);
		rc(8'h37, 16'h0004, 16'h0000);
		wr(8'hB0, 8'h00);
		wr(8'hB3, 8'h10);
		wr(8'hB0, 8'h81);
		wr(8'hB1, 8'h01);
		meas(1'b0, 1'b0, n);
		chk("phase low", 16'd478, 16'(n));
		wr(8'hB1, 8'h00);
	endtask
	// Watchdog: the whole sequence needs well under ten thousand cycles.
	initial begin
		#(25 * 30000);
		fails++;
		complete_run();
	end
	// Main sequence.
	initial begin
		{rst_n, reg_write, reg_read, ext_clk_tick, global_irq_enable} = 5'h00;
		{irq_ack_ovf, irq_ack_cmpa, irq_ack_cmpb} = 3'h0;
		{reg_addr, reg_wdata} = 16'h0000;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_clk();
		t_supp();
		t_cmpa();
		t_ovf();
		t_async();
		t_pwm();
		complete_run();
	end
endmodule
